// ---- src/tx_alarm_mask_and_lock_threshold.sv ----
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`include "tx_alarm_params.svh"

// Contract
// - Threshold bits 8:1 in reset-zero register
// - Threshold bits 13:9 in next register
// - Assert lock-loss when jitter exceeds threshold
// - Deassert lock-loss when jitter below threshold
// - Config bit 0 powers transmitter down
// - Mask bits 6:0 map seven alarm sources
// - Unmasked alarm drives interrupt when enabled
// - Masked alarm is ignored for interrupt
// - FIFO mask reads zero under auto recovery
// - Threshold lsb in bit 7 below
// - Sticky status cleared by zero or disable
module tx_alarm_mask_and_lock_threshold
    import tx_alarm_pkg::*;
#(
    parameter int THR_W = 14                      // Threshold width
) (
    input  wire logic             clk_i,          // Control clock
    input  wire logic             rst_i,          // Synchronous reset
    input  wire logic             cyc_i,          // Wishbone cycle
    input  wire logic             stb_i,          // Wishbone strobe
    input  wire logic             we_i,           // Wishbone write
    input  wire logic [31:0]      adr_i,          // Wishbone byte address
    input  wire logic [3:0]       sel_i,          // Wishbone byte select
    input  wire logic [31:0]      dat_i,          // Wishbone write data
    output logic      [31:0]      dat_o,          // Wishbone read data
    output logic                  ack_o,          // Wishbone acknowledge
    input  wire logic [THR_W-1:0] jitter_i,       // Measured jitter
    input  wire alarm_t           alarm_i,        // Alarm source levels
    output logic                  rx_lock_lost_o, // Receive lock lost
    output logic                  tx_power_down_o,// Transmitter power down
    output logic                  irq_o           // Interrupt output
);

    // Word index hit test, shared by read and write decode
    // Only the word index is compared; the byte offset and upper address bits are ignored,
    // so aliases of a register answer as the register itself
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] tgt);
        hit = (idx == tgt);
    endfunction

    logic [7:0]       idx;
    logic             req;
    logic             wr;
    logic [7:0]       wbyte;
    logic             ack_ff;
    logic [31:0]      dat_ff;
    logic [7:0]       thr_apply_ff;
    logic [7:0]       thr_low_ff;
    logic [7:0]       thr_mid_ff;
    logic [7:0]       thr_high_ff;
    logic [THR_W-1:0] thr_live_ff;
    logic [6:0]       tx_cfg_ff;
    logic [6:0]       mask_ff;
    logic [6:0]       eff_mask;
    logic [6:0]       status_ff;
    logic [6:0]       nxt_status;
    logic             global_en_ff;
    logic [7:0]       fifo_ctrl_ff;
    lock_state_t      lock_ff;
    logic             irq_ff;
    logic [THR_W-1:0] thr_prog;
    logic [7:0]       rdata;

    // Bus decode; a request is taken once, in the cycle before ack
    // Masking with ack stops a master that holds stb into the ack cycle from being
    // taken twice, which would repeat a write or a status clear.
    // Writes need the low byte lane, the only lane that carries data
    assign idx   = adr_i[9:2];
    assign req   = cyc_i & stb_i & ~ack_ff;
    assign wr    = req & we_i & sel_i[0];
    assign wbyte = dat_i[7:0];

    // Full programmed threshold: lsb below, mid byte, high bits
    // This is only the staged value; the comparator uses the copy taken on the strobe
    // so a half-written threshold never reaches the lock decision
    assign thr_prog = {thr_high_ff[`THR_HIGH_MSB:0], thr_mid_ff,
                       thr_low_ff[`THR_LOW_LSB_BIT]};

    // Mask as seen by software and by the interrupt logic
    // With automatic FIFO recovery on, the FIFO fault source reads as unmasked;
    // the interrupt path uses the same view so software never sees a mask
    // that differs from what actually gates the pin
    always_comb begin
        eff_mask = mask_ff;
        if (fifo_ctrl_ff[`FIFO_AUTO_BIT]) begin
            eff_mask[`MASK_FIFO_BIT] = 1'b0;
        end
    end

    // Acknowledge one cycle after the request
    // The answer always takes exactly one wait state, reads and writes alike,
    // and ack drops in the following cycle even if the strobe is still high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    // Read multiplexer
    // Unmapped indices return zero; reserved top bits of the narrow registers read zero.
    // The lock flag in the control word lets software poll the decision without the pin
    always_comb begin
        rdata = 8'h00;
        if (hit(idx, `IDX_THR_APPLY)) begin
            rdata = thr_apply_ff;
        end else if (hit(idx, `IDX_THR_LOW)) begin
            rdata = thr_low_ff;
        end else if (hit(idx, `IDX_THR_MID)) begin
            rdata = thr_mid_ff;
        end else if (hit(idx, `IDX_THR_HIGH)) begin
            rdata = thr_high_ff;
        end else if (hit(idx, `IDX_TX_CFG)) begin
            rdata = {1'b0, tx_cfg_ff};
        end else if (hit(idx, `IDX_ALARM_MASK)) begin
            rdata = {1'b0, eff_mask};
        end else if (hit(idx, `IDX_ALARM_STATUS)) begin
            rdata = {1'b0, status_ff};
        end else if (hit(idx, `IDX_IRQ_CTRL)) begin
            rdata = {(lock_ff == LOCK_LOST), 6'h00, global_en_ff};
        end else if (hit(idx, `IDX_FIFO_CTRL)) begin
            rdata = fifo_ctrl_ff;
        end
    end

    // Registered read data, zero for unmapped words
    // Captured at the taking edge so it stands unchanged while ack is high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_ff <= 32'h0000_0000;
        end else if (req) begin
            dat_ff <= {24'h00_0000, rdata};
        end
    end

    // Low threshold register; only bit 7 feeds the threshold
    // The reserved low bits are stored as written so read-back matches the host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_low_ff <= `RST_THR_LOW;
        end else if (wr && hit(idx, `IDX_THR_LOW)) begin
            thr_low_ff <= wbyte;
        end
    end

    // Mid threshold byte, threshold bits 8:1
    // A write here only stages the value; the strobe makes it live
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_mid_ff <= `RST_THR_MID;
        end else if (wr && hit(idx, `IDX_THR_MID)) begin
            thr_mid_ff <= wbyte;
        end
    end

    // High threshold bits 13:9 with the reserved pattern bits above them
    // The reserved bits are kept as written and never enforced
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_high_ff <= `RST_THR_HIGH;
        end else if (wr && hit(idx, `IDX_THR_HIGH)) begin
            thr_high_ff <= wbyte;
        end
    end

    // Index and strobe register; strobe bit clears itself next cycle
    // The index bits stay as written, so a later strobe write must carry the
    // index again; the strobe is high for exactly one cycle and a read always returns it as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_apply_ff <= `RST_THR_APPLY;
        end else if (wr && hit(idx, `IDX_THR_APPLY)) begin
            thr_apply_ff <= wbyte;
        end else begin
            thr_apply_ff[`APPLY_STROBE_BIT] <= 1'b0;
        end
    end

    // Threshold in force, copied on strobe with the right index
    // A strobe with any other index is ignored, so a stray write to the
    // strobe register cannot load a threshold that was not meant to apply
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_live_ff <= '0;
        end else if (thr_apply_ff[`APPLY_STROBE_BIT] &&
                     thr_apply_ff[`APPLY_ADDR_MSB:0] == `APPLY_INDEX_VAL) begin
            thr_live_ff <= thr_prog;
        end
    end

    // Lock decision holds when jitter equals the threshold
    // The equal band is a one-count hysteresis: a measure sitting on the
    // threshold does not make the flag toggle from cycle to cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_ff <= LOCK_HELD;
        end else if (jitter_i > thr_live_ff) begin
            lock_ff <= LOCK_LOST;
        end else if (jitter_i < thr_live_ff) begin
            lock_ff <= LOCK_HELD;
        end
    end

    // Transmitter configuration; bit 1 is read-only
    // Bit 7 is not stored and reads zero; the other reserved bits keep what
    // the host wrote. Leaving power down needs a recalibration by the host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_cfg_ff <= `RST_TX_CFG;
        end else if (wr && hit(idx, `IDX_TX_CFG)) begin
            tx_cfg_ff[6:2]             <= wbyte[6:2];
            tx_cfg_ff[`TX_CFG_PDN_BIT] <= wbyte[`TX_CFG_PDN_BIT];
        end
    end

    // Alarm mask
    // Resets to all masked so no source can raise the pin before software
    // has chosen which alarms it wants to hear about
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= `RST_ALARM_MASK;
        end else if (wr && hit(idx, `IDX_ALARM_MASK)) begin
            mask_ff <= wbyte[6:0];
        end
    end

    // Global interrupt enable
    // Clearing it also wipes the sticky bits, so re-enabling starts clean
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_en_ff <= `RST_IRQ_CTRL;
        end else if (wr && hit(idx, `IDX_IRQ_CTRL)) begin
            global_en_ff <= wbyte[`CTRL_GLOBAL_BIT];
        end
    end

    // FIFO control; only the automatic recovery bit has an effect here
    // The rest of the byte is kept for software read-back
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_ctrl_ff <= `RST_FIFO_CTRL;
        end else if (wr && hit(idx, `IDX_FIFO_CTRL)) begin
            fifo_ctrl_ff <= wbyte;
        end
    end

    // Sticky bits: a live alarm wins over any clear in the same cycle
    // Losing an alarm that arrives with a clear would hide a real event from
    // software, so the set is applied last. A write of one to the status word
    // leaves a bit alone; only zero clears it there
    generate
        for (genvar i = 0; i < 7; i++) begin : g_sticky
            always_comb begin
                nxt_status[i] = status_ff[i];
                if (!global_en_ff) begin
                    nxt_status[i] = 1'b0;
                end
                if (wr && hit(idx, `IDX_ALARM_STATUS) && !wbyte[i]) begin
                    nxt_status[i] = 1'b0;
                end
                if (wr && hit(idx, `IDX_ALARM_CLEAR) && wbyte[i]) begin
                    nxt_status[i] = 1'b0;
                end
                if (alarm_i[i]) begin
                    nxt_status[i] = 1'b1;
                end
            end
        end
    endgenerate

    // Status register
    // Holds the next value worked out bit by bit above
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_ff <= 7'h00;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Interrupt: unmasked sticky bits gated by global enable
    // Registered so the pin is glitch free; it lags the status bit by one cycle
    // and falls one cycle after the last unmasked bit is cleared or masked
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= global_en_ff & (|(status_ff & ~eff_mask));
        end
    end

    // Outputs straight from flip-flops
    // No logic sits between these registers and the pins
    assign dat_o           = dat_ff;
    assign ack_o           = ack_ff;
    assign rx_lock_lost_o  = (lock_ff == LOCK_LOST);
    assign tx_power_down_o = tx_cfg_ff[`TX_CFG_PDN_BIT];
    assign irq_o           = irq_ff;

endmodule // tx_alarm_mask_and_lock_threshold

// ---- include/tx_alarm_params.svh ----
`ifndef TX_ALARM_PARAMS_SVH
`define TX_ALARM_PARAMS_SVH

// Register word indices; byte address is four times the index
`define IDX_THR_APPLY     8'h6A
`define IDX_THR_LOW       8'h6B
`define IDX_THR_MID       8'h6C
`define IDX_THR_HIGH      8'h6D
`define IDX_TX_CFG        8'h83
`define IDX_ALARM_MASK    8'h84
`define IDX_ALARM_STATUS  8'h85
`define IDX_IRQ_CTRL      8'h90
`define IDX_ALARM_CLEAR   8'h91
`define IDX_FIFO_CTRL     8'h9C

// Reset values
`define RST_THR_APPLY     8'h00
`define RST_THR_LOW       8'h00
`define RST_THR_MID       8'h00
`define RST_THR_HIGH      8'h00
`define RST_TX_CFG        7'h22
`define RST_ALARM_MASK    7'h7F
`define RST_IRQ_CTRL      1'h0
`define RST_FIFO_CTRL     8'h00

// Field positions
`define THR_LOW_LSB_BIT   7
`define THR_HIGH_MSB      4
`define APPLY_STROBE_BIT  7
`define APPLY_ADDR_MSB    5
`define APPLY_INDEX_VAL   6'h04
`define TX_CFG_PDN_BIT    0
`define TX_CFG_RO_BIT     1
`define MASK_FIFO_BIT     3
`define FIFO_AUTO_BIT     1
`define CTRL_GLOBAL_BIT   0
`define CTRL_LOCK_BIT     7

`endif

// ---- include/tx_alarm_pkg.sv ----
package tx_alarm_pkg;

    // Alarm sources, bit 6 down to bit 0 of mask and status
    typedef struct packed {
        logic ref_clock_absent_alarm;
        logic signal_absent_alarm;
        logic lock_lost_alarm;
        logic tx_fifo_fault_alarm;
        logic pattern_mismatch_alarm;
        logic pattern_sync_dropped_alarm;
        logic signal_quality_alarm;
    } alarm_t;

    // Receive lock decision
    typedef enum logic {
        LOCK_HELD,
        LOCK_LOST
    } lock_state_t;

endpackage

// ---- testbench/tx_alarm_assertions.sv ----
`timescale 1ns/10ps
// Port-level checks on bus answers, lock, power and interrupt
module tx_alarm_assertions
    import tx_alarm_pkg::*;
#(
    parameter int THR_W = 14                  // Threshold width
) (
    input wire logic             clk_i,          // Control clock
    input wire logic             rst_i,          // Synchronous reset
    input wire logic             cyc_i,          // Cycle
    input wire logic             stb_i,          // Strobe
    input wire logic             we_i,           // Write
    input wire logic [31:0]      adr_i,          // Byte address
    input wire logic [3:0]       sel_i,          // Byte select
    input wire logic [31:0]      dat_i,          // Write data
    input wire logic [31:0]      dat_o,          // Read data
    input wire logic             ack_o,          // Acknowledge
    input wire logic [THR_W-1:0] jitter_i,       // Measured jitter
    input wire alarm_t           alarm_i,        // Alarm levels
    input wire logic             rx_lock_lost_o, // Lock lost
    input wire logic             tx_power_down_o,// Power down
    input wire logic             irq_o           // Interrupt
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Bus answer timing and lanes
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held past one cycle");
    rdata_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    // Lock decision against the jitter that caused it
    lock_rise_a: assert property ($rose(rx_lock_lost_o) |-> $past(jitter_i) != '0)
        else $error("lock lost with zero jitter");
    lock_fall_a: assert property ($fell(rx_lock_lost_o) |-> $past(jitter_i) != '1)
        else $error("lock regained at full jitter");
    // Power and interrupt change only for a cause
    pdn_write_a: assert property ($changed(tx_power_down_o) |-> ack_o)
        else $error("power down moved without a write");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(alarm_i, 2) != '0 || $past(ack_o))
        else $error("interrupt rose without alarm or write");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(ack_o))
        else $error("interrupt fell without a write");
    cover property ($rose(irq_o));
    cover property ($rose(rx_lock_lost_o));
    cover property ($rose(tx_power_down_o));
endmodule // tx_alarm_assertions

// ---- testbench/host_bus_master.sv ----
`timescale 1ns/10ps
// Host side of the register bus, one classic cycle per call
module host_bus_master (
    input  wire logic        clk_i, // Control clock
    input  wire logic        ack_i, // Slave acknowledge
    input  wire logic [31:0] dat_i, // Slave read data
    output logic             cyc_o, // Cycle
    output logic             stb_o, // Strobe
    output logic             we_o,  // Write
    output logic [31:0]      adr_o, // Byte address
    output logic [3:0]       sel_o, // Byte select
    output logic [31:0]      dat_o  // Write data
);
    // Idle bus at time zero
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // Request held until ack is sampled; the gap edge keeps stb low a cycle
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, sel_o} <= {2'b11, w, 4'hF};
        adr_o <= {22'h0, idx, 2'b00};
        dat_o <= {24'h0, wd};
        do @(posedge clk_i);
        while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        {cyc_o, stb_o} <= 2'b00;
    endtask
    // Recalibration after power-up is issued by the host outside this bank
endmodule // host_bus_master

// ---- testbench/tx_alarm_mask_and_lock_threshold_bench.sv ----
`timescale 1ns/10ps
`include "tx_alarm_params.svh"
module tx_alarm_mask_and_lock_threshold_bench
    import tx_alarm_pkg::*;
;
    logic        clk_i, rst_i, cyc, stb, we, ack, irq, lost, pdn;
    logic [31:0] adr, wdat, rdat;
    logic [3:0]  sel;
    logic [13:0] jitter;
    logic [7:0]  rd;
    alarm_t      alarm;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [13:0] jt [3] = '{14'h0B58, 14'h0B57, 14'h0B56};
    logic        ex [3] = '{1'b1, 1'b1, 1'b0};

    tx_alarm_mask_and_lock_threshold #(.THR_W(14)) tx_alarm_mask_and_lock_threshold_inst (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .jitter_i(jitter), .alarm_i(alarm), .rx_lock_lost_o(lost),
        .tx_power_down_o(pdn), .irq_o(irq));
    host_bus_master host_bus_master_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // Clock and cycle ceiling
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // Comparisons and bus helpers
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({7'h0, got}, {7'h0, exp});
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        host_bus_master_inst.xfer(1'b1, idx, val, rd);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        host_bus_master_inst.xfer(1'b0, idx, 8'h00, rd);
        chk_reg(rd, exp);
    endtask
    task automatic pulse(input alarm_t a);
        @(posedge clk_i);
        alarm <= a;
        @(posedge clk_i);
        alarm <= '0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d, comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {jitter, alarm} = '0;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(`IDX_THR_MID, 8'h00);
        rd_chk(`IDX_THR_HIGH, 8'h00);
        rd_chk(`IDX_TX_CFG, 8'h22);
        rd_chk(8'h40, 8'h00);
        chk_pin(pdn, 1'b0);
        wr(`IDX_THR_LOW, 8'hA0);
        wr(`IDX_THR_MID, 8'hAB);
        wr(`IDX_THR_HIGH, 8'hA5);
        rd_chk(`IDX_THR_MID, 8'hAB);
        rd_chk(`IDX_THR_HIGH, 8'hA5);
        wr(`IDX_THR_APPLY, 8'h04);
        wr(`IDX_THR_APPLY, 8'h84);
        // Above, equal and below the threshold 0x0B57
        for (int i = 0; i < 3; i++) begin
            jitter <= jt[i];
            repeat (3) @(posedge clk_i);
            chk_pin(lost, ex[i]);
        end
        wr(`IDX_TX_CFG, 8'h23);
        chk_pin(pdn, 1'b1);
        rd_chk(`IDX_TX_CFG, 8'h23);
        wr(`IDX_TX_CFG, 8'hA2);
        rd_chk(`IDX_TX_CFG, 8'h22);
        chk_pin(pdn, 1'b0);
        wr(`IDX_IRQ_CTRL, 8'h01);
        wr(`IDX_ALARM_MASK, 8'hFF);
        rd_chk(`IDX_ALARM_MASK, 8'h7F);
        // Each source alone unmasked, then a masked neighbour
        for (int i = 0; i < 7; i++) begin
            wr(`IDX_ALARM_MASK, (~(8'h01 << i)) & 8'h7F);
            wr(`IDX_ALARM_CLEAR, 8'h7F);
            pulse(7'(1 << i));
            chk_pin(irq, 1'b1);
            rd_chk(`IDX_ALARM_STATUS, 8'(1 << i));
            wr(`IDX_ALARM_CLEAR, 8'h7F);
            pulse(7'(1 << ((i + 1) % 7)));
            chk_pin(irq, 1'b0);
        end
        // Writing zero clears a status bit, writing one leaves it set
        pulse(7'h03);
        wr(`IDX_ALARM_STATUS, 8'h02);
        rd_chk(`IDX_ALARM_STATUS, 8'h02);
        pulse(7'h01);
        wr(`IDX_IRQ_CTRL, 8'h00);
        rd_chk(`IDX_ALARM_STATUS, 8'h00);
        wr(`IDX_FIFO_CTRL, 8'h02);
        wr(`IDX_ALARM_MASK, 8'h7F);
        rd_chk(`IDX_ALARM_MASK, 8'h77);
        tally_and_finish();
    end
endmodule // tx_alarm_mask_and_lock_threshold_bench

bind tx_alarm_mask_and_lock_threshold tx_alarm_assertions #(.THR_W(THR_W)) tx_alarm_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .jitter_i(jitter_i), .alarm_i(alarm_i),
    .rx_lock_lost_o(rx_lock_lost_o), .tx_power_down_o(tx_power_down_o), .irq_o(irq_o));
